/* File: rtl/i2cs_sequencer.sv */
// Purpose: master write and address-only transaction sequencing on SDA/SCL
// Assumes: software drives the control strobes on core_clk; pins are open drain
// Notes: each bit takes four quarter ticks; SCL is made here, not sampled
//
// Overview of operation
// - start request plus waiting byte gives START, then shift register loads.
// - after first address bit shifts out, empty flag sets and irq asserts.
// - during a data byte the transmit irq asserts after its first bit.
// - data register copies into shift register before each next byte.
// - ack status is one when slave holds SDA low, else zero.
// - nack with no stop or start request sets nack flag and interrupt.
// - after STOP following a nack, stop request and nack flag clear.
// - stop or start already requested suppresses the nack interrupt.
// - after final byte send STOP or repeated START, clear that request.
// - probe sends START, address, samples ack, STOP, then clears stop request.
// - no START until start request is set and data register written.
// - a data register write clears the empty flag unless a flush or the first-bit set comes in the same cycle.
// - empty flag at ack cycle without stop or start stalls the bus.
// - after a nack stay paused until stop or start request is set.
`timescale 1ns/100ps
module i2cs_sequencer #(
    parameter int QUARTER_CYCLES = i2cs_pkg::QUARTER_CYCLES
) (
    input wire logic core_clk,
    input wire logic arst_n,
    input wire logic controller_enable,
    input wire logic transmit_irq_enable,
    input wire i2cs_pkg::i2cs_cmd_type cmd,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe,
    output logic scl_o,
    output logic scl_oe,
    output logic start_req,
    output logic stop_req,
    output logic transmit_empty_flag,
    output logic not_acknowledge_flag,
    output logic ack_status,
    output logic busy,
    output logic irq
);

    i2cs_pkg::i2cs_state_type state_q, state_d;
    logic [1:0] phase_q, phase_d;
    logic [2:0] bit_q, bit_d;
    logic [7:0] shift_q, shift_d;
    logic [7:0] data_q, data_d;
    logic empty_q, empty_d;
    logic start_q, start_d;
    logic stop_q, stop_d;
    logic nack_q, nack_d;
    logic ack_q, ack_d;
    logic busy_q, busy_d;
    logic irq_q, irq_d;
    i2cs_pkg::i2cs_drive_type drv_q, drv_d;
    logic sda_meta_q, sda_sync_q, zero_q, tick;

    i2cs_quarter_tick #(
        .QUARTER_CYCLES(QUARTER_CYCLES)
    ) u_tick (
        .core_clk(core_clk),
        .arst_n(arst_n),
        .tick(tick)
    );

    // ==========================================================
    // pin synchroniser: SDA comes from another domain
    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            sda_meta_q <= 1'b1;
            sda_sync_q <= 1'b1;
            zero_q <= 1'b0;
        end
        else
        begin
            sda_meta_q <= sda_i;
            sda_sync_q <= sda_meta_q;
            zero_q <= 1'b0;
        end
    end

    // ==========================================================
    // sequencer next state
    always_comb
    begin
        state_d = state_q;
        phase_d = phase_q;
        bit_d = bit_q;
        shift_d = shift_q;
        start_d = start_q | cmd.start_set;
        stop_d = stop_q | cmd.stop_set;
        nack_d = nack_q;
        ack_d = ack_q;
        drv_d = drv_q;
        // software side of the data register; a flush beats a same-cycle write
        data_d = cmd.data_wr ? cmd.data : data_q;
        empty_d = cmd.flush | (empty_q & ~cmd.data_wr);
        if (!controller_enable)
        begin
            // disabling drops the bus at once; no clean stop is attempted
            state_d = i2cs_pkg::ST_IDLE;
            phase_d = 2'd0;
            drv_d = '0;
        end
        else if (tick)
        begin
            phase_d = phase_q + 2'd1;
            case (state_q)
                i2cs_pkg::ST_IDLE:
                begin
                    phase_d = 2'd0;
                    drv_d = '0;
                    if (start_q && !empty_q)
                    begin
                        state_d = i2cs_pkg::ST_START;
                    end
                end
                i2cs_pkg::ST_WAIT_DATA:
                begin
                    // restart waits with SCL low for the next address byte
                    phase_d = 2'd0;
                    drv_d.sda_oe = 1'b0;
                    if (!empty_q)
                    begin
                        state_d = i2cs_pkg::ST_START;
                    end
                end
                i2cs_pkg::ST_START:
                begin
                    case (phase_q)
                        2'd0: drv_d = '0;
                        2'd1: drv_d.sda_oe = 1'b1; // SDA falls while SCL high
                        2'd2: drv_d.scl_oe = 1'b1;
                        default:
                        begin
                            shift_d = data_q;
                            start_d = cmd.start_set;
                            nack_d = 1'b0;
                            bit_d = 3'd0;
                            state_d = i2cs_pkg::ST_SHIFT;
                        end
                    endcase
                end
                i2cs_pkg::ST_SHIFT:
                begin
                    case (phase_q)
                        2'd0: drv_d.sda_oe = ~shift_q[7];
                        2'd1: drv_d.scl_oe = 1'b0;
                        2'd2: drv_d.scl_oe = 1'b0;
                        default:
                        begin
                            drv_d.scl_oe = 1'b1;
                            shift_d = {shift_q[6:0], 1'b0};
                            bit_d = bit_q + 3'd1;
                            empty_d = empty_d | (bit_q == 3'd0); // set wins
                            if (bit_q == 3'(i2cs_pkg::BYTE_BITS - 1))
                            begin
                                state_d = i2cs_pkg::ST_ACK;
                            end
                        end
                    endcase
                end
                i2cs_pkg::ST_ACK:
                begin
                    case (phase_q)
                        2'd0:
                        begin
                            drv_d.sda_oe = 1'b0;
                            if (empty_q && !start_q && !stop_q)
                            begin
                                phase_d = 2'd0; // stall with SCL low
                            end
                        end
                        2'd1: drv_d.scl_oe = 1'b0;
                        2'd2: ack_d = ~sda_sync_q;
                        default:
                        begin
                            drv_d.scl_oe = 1'b1;
                            if (stop_q)
                            begin
                                state_d = i2cs_pkg::ST_STOP;
                            end
                            else if (start_q)
                            begin
                                state_d = i2cs_pkg::ST_WAIT_DATA;
                            end
                            else if (!ack_q)
                            begin
                                nack_d = 1'b1;
                                state_d = i2cs_pkg::ST_PAUSE;
                            end
                            else
                            begin
                                shift_d = data_q;
                                bit_d = 3'd0;
                                state_d = i2cs_pkg::ST_SHIFT;
                            end
                        end
                    endcase
                end
                i2cs_pkg::ST_PAUSE:
                begin
                    phase_d = 2'd0;
                    if (stop_q)
                    begin
                        state_d = i2cs_pkg::ST_STOP;
                    end
                    else if (start_q)
                    begin
                        state_d = i2cs_pkg::ST_WAIT_DATA;
                    end
                end
                default:
                begin
                    case (phase_q)
                        2'd0: drv_d.sda_oe = 1'b1;
                        2'd1: drv_d.scl_oe = 1'b0;
                        2'd2: drv_d.sda_oe = 1'b0; // SDA rises while SCL high
                        default:
                        begin
                            stop_d = cmd.stop_set;
                            nack_d = 1'b0;
                            state_d = i2cs_pkg::ST_IDLE;
                        end
                    endcase
                end
            endcase
        end
        busy_d = (state_d != i2cs_pkg::ST_IDLE);
        // transmit irq is masked by its enable; nack needs only the controller enable
        irq_d = controller_enable &
            ((empty_d & transmit_irq_enable) | nack_d);
    end

    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            state_q <= i2cs_pkg::ST_IDLE;
            phase_q <= 2'd0;
            bit_q <= 3'd0;
            shift_q <= i2cs_pkg::DATA_RESET;
            data_q <= i2cs_pkg::DATA_RESET;
            empty_q <= i2cs_pkg::TX_EMPTY_RESET;
            start_q <= 1'b0;
            stop_q <= 1'b0;
            nack_q <= 1'b0;
            ack_q <= 1'b0;
            busy_q <= 1'b0;
            irq_q <= 1'b0;
            drv_q <= '0;
        end
        else
        begin
            state_q <= state_d;
            phase_q <= phase_d;
            bit_q <= bit_d;
            shift_q <= shift_d;
            data_q <= data_d;
            empty_q <= empty_d;
            start_q <= start_d;
            stop_q <= stop_d;
            nack_q <= nack_d;
            ack_q <= ack_d;
            busy_q <= busy_d;
            irq_q <= irq_d;
            drv_q <= drv_d;
        end
    end

    // ==========================================================
    // outputs, all straight from flops
    assign sda_o = zero_q;
    assign scl_o = zero_q;
    assign sda_oe = drv_q.sda_oe;
    assign scl_oe = drv_q.scl_oe;
    assign start_req = start_q;
    assign stop_req = stop_q;
    assign transmit_empty_flag = empty_q;
    assign not_acknowledge_flag = nack_q;
    assign ack_status = ack_q;
    assign busy = busy_q;
    assign irq = irq_q;

endmodule : i2cs_sequencer

/* File: rtl/i2cs_pkg.sv */
// Purpose: shared constants and types for the i2c master transaction sequencer
// Assumes: core clock at 200 MHz, standard-mode SCL
// Notes: every count derives from a time in its own unit and the clock rate
package i2cs_pkg;

    // ==========================================================
    // timing
    localparam int CLK_PERIOD_PS = 5000;
    localparam int SCL_PERIOD_NS = 10000;
    // one SCL period is cut into four quarters; a longest time rounds down
    localparam int QUARTER_CYCLES = (SCL_PERIOD_NS * 1000 / 4) / CLK_PERIOD_PS;

    // ==========================================================
    // byte framing and reset values
    localparam int BYTE_BITS = 8;
    localparam logic [7:0] DATA_RESET = 8'h00;
    localparam logic TX_EMPTY_RESET = 1'b1;

    // ==========================================================
    // types
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_WAIT_DATA,
        ST_START,
        ST_SHIFT,
        ST_ACK,
        ST_PAUSE,
        ST_STOP
    } i2cs_state_type;

    // one-cycle software strobes with the byte that a data write carries
    typedef struct packed {
        logic start_set;
        logic stop_set;
        logic flush;
        logic data_wr;
        logic [7:0] data;
    } i2cs_cmd_type;

    // open-drain enables: high pulls the line low
    typedef struct packed {
        logic scl_oe;
        logic sda_oe;
    } i2cs_drive_type;

endpackage : i2cs_pkg

/* File: rtl/i2cs_quarter_tick.sv */
// Purpose: divides the core clock down to a quarter-period tick for SCL
// Assumes: QUARTER_CYCLES of at least two
// Notes: free running; the sequencer steps one phase per tick
`timescale 1ns/100ps
module i2cs_quarter_tick #(
    parameter int QUARTER_CYCLES = i2cs_pkg::QUARTER_CYCLES
) (
    input wire logic core_clk,
    input wire logic arst_n,
    output logic tick
);

    localparam int CW = $clog2(QUARTER_CYCLES);
    localparam logic [CW-1:0] LAST = CW'(QUARTER_CYCLES - 1);

    logic [CW-1:0] cnt_q;
    logic [CW-1:0] cnt_d;
    logic tick_q;
    logic tick_d;

    // ==========================================================
    // divider
    always_comb
    begin
        cnt_d = (cnt_q == LAST) ? '0 : cnt_q + 1'b1;
        tick_d = (cnt_q == LAST);
    end

    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            cnt_q <= '0;
            tick_q <= 1'b0;
        end
        else
        begin
            cnt_q <= cnt_d;
            tick_q <= tick_d;
        end
    end

    assign tick = tick_q;

endmodule : i2cs_quarter_tick

/* File: verif/i2cs_sequencer_chk.sv */
// Purpose: port-level assertions for the i2c transaction sequencer
// Assumes: bound onto every i2cs_sequencer instance
// Notes: an oe of one pulls its line low
`timescale 1ns/100ps
module i2cs_sequencer_chk (
    input wire logic core_clk,
    input wire logic arst_n,
    input wire logic controller_enable,
    input wire logic transmit_irq_enable,
    input wire i2cs_pkg::i2cs_cmd_type cmd,
    input wire logic sda_oe,
    input wire logic scl_oe,
    input wire logic start_req,
    input wire logic stop_req,
    input wire logic transmit_empty_flag,
    input wire logic not_acknowledge_flag,
    input wire logic ack_status,
    input wire logic busy,
    input wire logic irq
);
    // ==========================================================
    // one clock domain, so clocking and reset are given once
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!arst_n);

    // ==========================================================
    // bus framing
    a_start_gated: assert property ($rose(sda_oe) && !scl_oe
        |-> start_req && !transmit_empty_flag)
        else $error("start seen without request and data");
    a_sda_scl_low: assert property ($changed(sda_oe) |-> scl_oe || $past(scl_oe)
        || start_req || stop_req || !$past(controller_enable))
        else $error("sda moved while scl high");
    a_start_done: assert property ($fell(start_req) && controller_enable
        |-> sda_oe && scl_oe)
        else $error("start request cleared before start condition");
    a_stop_done: assert property ($fell(stop_req) && controller_enable
        |-> !not_acknowledge_flag && !sda_oe && !scl_oe)
        else $error("stop request cleared before stop condition");
    a_nack_pause: assert property (not_acknowledge_flag && !start_req && !stop_req
        && controller_enable && !cmd.start_set && !cmd.stop_set
        |=> $stable(sda_oe) && $stable(scl_oe))
        else $error("bus moved while paused");

    // ==========================================================
    // flags and interrupt
    a_write_clears: assert property (cmd.data_wr && !cmd.flush && !busy
        |=> !transmit_empty_flag)
        else $error("empty flag kept after write");
    a_empty_irq: assert property ($rose(transmit_empty_flag) && controller_enable
        && transmit_irq_enable |=> irq)
        else $error("no irq on empty");
    a_irq_masked: assert property ((!transmit_irq_enable && !not_acknowledge_flag)[*2]
        |-> !irq)
        else $error("irq while masked");
    a_nack_raise: assert property ($rose(not_acknowledge_flag) && controller_enable
        |-> !ack_status && !start_req && !stop_req ##1 irq)
        else $error("bad nack raise");
endmodule : i2cs_sequencer_chk

bind i2cs_sequencer i2cs_sequencer_chk u_i2cs_sequencer_chk (.core_clk, .arst_n,
    .controller_enable, .transmit_irq_enable, .cmd, .sda_oe, .scl_oe, .start_req, .stop_req,
    .transmit_empty_flag, .not_acknowledge_flag, .ack_status, .busy, .irq);

/* File: verif/i2cs_slave_model.sv */
// Purpose: behavioural i2c slave taking write bytes and answering the ack bit
// Assumes: scl and sda are resolved line levels with pull-ups
// Notes: with ack_en low the ack bit is left to the pull-up
`timescale 1ns/100ps
module i2cs_slave_model (
    input wire logic scl,
    input wire logic sda,
    input wire logic ack_en,
    output logic sda_pull,
    output logic [7:0] last_byte,
    output int n_bytes,
    output int n_starts,
    output int n_stops
);
    // ==========================================================
    // bit state
    logic [7:0] shift;
    int bit_cnt;
    initial
    begin
        sda_pull = 1'b0;
        last_byte = 8'h00;
        shift = 8'h00;
        {n_bytes, n_starts, n_stops, bit_cnt} = '0;
    end
    // start and stop are sda edges with scl high
    always @(negedge sda)
        if (scl)
        begin
            n_starts++;
            bit_cnt = 0;
        end
    always @(posedge sda)
        if (scl)
            n_stops++;
    // sample on rising scl; the ninth clock is the ack
    always @(posedge scl)
    begin
        if (bit_cnt < 8)
            shift = {shift[6:0], sda};
        if (bit_cnt == 7)
        begin
            last_byte = shift;
            n_bytes++;
        end
        bit_cnt++;
    end
    // hold the ack from the fall after bit eight to the next fall
    always @(negedge scl)
        if (bit_cnt == 8)
            sda_pull = ack_en;
        else if (bit_cnt == 9)
        begin
            sda_pull = 1'b0;
            bit_cnt = 0;
        end
endmodule : i2cs_slave_model

/* File: verif/test_i2c_master_transaction_sequencer.sv */
// Purpose: self-checking bench for the transaction sequencer
// Assumes: short quarter count; inputs move on the falling edge
// Notes: the bench plays software, the slave model the far side
`timescale 1ns/100ps
module test_i2c_master_transaction_sequencer;
    // ==========================================================
    // stimulus and wires
    localparam logic [3:0] STA = 4'h8, STO = 4'h4, FL = 4'h2, WR = 4'h1;
    logic core_clk = 1'b0, arst_n = 1'b0, controller_enable = 1'b0, transmit_irq_enable = 1'b0;
    logic ack_en = 1'b1;
    i2cs_pkg::i2cs_cmd_type cmd = '0;
    logic sda_oe, scl_oe, start_req, stop_req, transmit_empty_flag, not_acknowledge_flag;
    logic ack_status, busy, irq, sda_pull, sda_o, scl_o;
    logic [7:0] last_byte;
    int n_bytes, n_starts, n_stops, miscompares = 0, n_tests = 0, cycles = 0, b, s;
    // open-drain lines: a driven pin shows its output value, a released one the pull-up
    wire logic sda_w = ~((sda_oe & ~sda_o) | sda_pull);
    wire logic scl_w = ~(scl_oe & ~scl_o);

    i2cs_sequencer #(.QUARTER_CYCLES(4)) u_i2cs_sequencer (.core_clk, .arst_n,
        .controller_enable, .transmit_irq_enable, .cmd, .sda_i(sda_w), .sda_o, .sda_oe,
        .scl_o, .scl_oe, .start_req, .stop_req, .transmit_empty_flag,
        .not_acknowledge_flag, .ack_status, .busy, .irq);
    i2cs_slave_model u_i2cs_slave_model (.scl(scl_w), .sda(sda_w), .ack_en, .sda_pull,
        .last_byte, .n_bytes, .n_starts, .n_stops);

    always #2.5 core_clk = ~core_clk;

    // ==========================================================
    // shared tasks
    task automatic check(input string name, input logic [7:0] exp, input logic [7:0] got);
        n_tests++;
        if (got !== exp)
        begin
            miscompares++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
        end
    endtask : check

    // one-cycle command strobe
    task automatic send(input logic [3:0] s, input logic [7:0] d);
        @(negedge core_clk);
        cmd = {s, d};
        @(negedge core_clk);
        cmd = '0;
    endtask : send

    // 0: transfer finished, 1: empty flag set, 2: nack flag set
    task automatic wait_for(input int which);
        int i;
        for (i = 0; i < 3000; i++)
        begin
            @(negedge core_clk);
            if ((which == 0 && stop_req === 1'b0 && busy === 1'b0)
                || (which == 1 && transmit_empty_flag === 1'b1)
                || (which == 2 && not_acknowledge_flag === 1'b1))
                break;
        end
        check("wait", 8'h01, {7'h00, i < 3000});
    endtask : wait_for

    task automatic finish_test;
        if (miscompares == 0 && n_tests > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : finish_test

    // ==========================================================
    // scenarios
    task automatic enable_seq;
        check("reset empty", 8'h01, transmit_empty_flag);
        controller_enable = 1'b1;
        repeat (3) @(negedge core_clk);
        check("masked irq", 8'h00, irq);
        transmit_irq_enable = 1'b1;
        repeat (2) @(negedge core_clk);
        check("empty irq", 8'h01, irq);
    endtask : enable_seq

    task automatic probe(input logic acked);
        ack_en = acked;
        send(WR, 8'hA0);
        check("write clears empty", 8'h00, transmit_empty_flag);
        repeat (20) @(negedge core_clk);
        check("no start unrequested", 8'h00, busy);
        s = n_stops;
        transmit_irq_enable = 1'b0;
        send(STA | STO, 8'h00);
        wait_for(0);
        check("probe ack", {7'h00, acked}, ack_status);
        check("probe nack", 8'h00, not_acknowledge_flag);
        check("probe byte", 8'hA0, last_byte);
        check("probe stop", 8'h01, 8'(n_stops - s));
    endtask : probe

    task automatic write_restart;
        ack_en = 1'b1;
        transmit_irq_enable = 1'b1;
        s = n_starts;
        send(WR, 8'hA4);
        send(STA, 8'h00);
        wait_for(1);
        @(negedge core_clk);
        check("addr irq", 8'h01, irq);
        b = n_bytes;
        repeat (300) @(negedge core_clk);
        check("stall scl", 8'h01, scl_oe);
        check("stall bytes", 8'h01, 8'(n_bytes - b));
        send(WR, 8'h3C);
        wait_for(1);
        @(negedge core_clk);
        check("data irq", 8'h01, irq);
        send(STA | WR, 8'hF2);
        wait_for(1);
        check("data byte", 8'h3C, last_byte);
        check("restart", 8'h02, 8'(n_starts - s));
        check("start cleared", 8'h00, start_req);
        send(WR, 8'h5A);
        wait_for(1);
        transmit_irq_enable = 1'b0;
        send(STO, 8'h00);
        wait_for(0);
        check("second addr", 8'h5A, last_byte);
        check("all bytes", 8'h04, 8'(n_bytes - b));
        check("ten bit ack", 8'h01, ack_status);
    endtask : write_restart

    task automatic nack_abort;
        ack_en = 1'b0;
        transmit_irq_enable = 1'b1;
        send(WR, 8'hB0);
        send(STA, 8'h00);
        wait_for(1);
        send(WR, 8'h11);
        wait_for(2);
        @(negedge core_clk);
        check("nack ack", 8'h00, ack_status);
        check("nack irq", 8'h01, irq);
        s = n_stops;
        b = n_bytes;
        repeat (100) @(negedge core_clk);
        check("paused", 8'h00, 8'(n_bytes - b + n_stops - s));
        transmit_irq_enable = 1'b0;
        send(STO | FL, 8'h00);
        wait_for(0);
        check("nack cleared", 8'h00, not_acknowledge_flag);
        check("flushed", 8'h01, transmit_empty_flag);
        check("abort stop", 8'h01, 8'(n_stops - s));
    endtask : nack_abort

    // dropping the enable mid-byte must release both lines at once and drop busy and irq
    task automatic disable_abort;
        send(WR, 8'hA0);
        send(STA | STO, 8'h00);
        wait_for(1);
        controller_enable = 1'b0;
        repeat (2) @(negedge core_clk);
        check("disable lines", 8'h00, {6'h00, sda_oe, scl_oe});
        check("disable busy irq", 8'h00, {6'h00, busy, irq});
    endtask : disable_abort

    // ==========================================================
    // main sequence and hang guard
    initial
    begin
        repeat (8) @(negedge core_clk);
        arst_n = 1'b1;
        enable_seq();
        probe(1'b0);
        probe(1'b1);
        write_restart();
        nack_abort();
        disable_abort();
        finish_test();
    end

    always @(posedge core_clk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            miscompares++;
            finish_test();
        end
    end
endmodule : test_i2c_master_transaction_sequencer
